//--- dv/pdw_cpu_model.sv
`timescale 1ns/1ps
// Stands in for the CPU core and the wake sources; every request from the bench
// reaches the block one edge later, so all of them move right after a clock edge.
module pdw_cpu_model (
  input  wire logic       i_clk,
  input  wire logic       i_halt_req,
  input  wire logic       i_rst_req,
  input  wire logic [7:0] i_pins,
  input  wire logic [7:0] i_irq,
  output logic            o_halt,
  output logic            o_rst_pin_n,
  output logic [7:0]      o_porta,
  output logic [7:0]      o_int_req
);
  initial begin
    o_halt      = 1'b0;
    o_rst_pin_n = 1'b1;
    o_porta     = 8'h00;
    o_int_req   = 8'h00;
  end
  always @(posedge i_clk) begin
    o_halt      <= i_halt_req;
    o_rst_pin_n <= !i_rst_req;
    o_porta     <= i_pins;
    o_int_req   <= i_irq;
  end
endmodule

//--- dv/pdw_power_ctrl_sva.sv
`timescale 1ns/1ps
module pdw_power_ctrl_sva (
  input wire logic       i_clk,
  input wire logic       i_nrst,
  input wire logic [1:0] i_addr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_halt,
  input wire logic       i_wdt_ovf,
  input wire logic       i_wdt_src_low,
  input wire logic       i_ext_rst_pin_n,
  input wire logic       i_lvd_low,
  input wire logic       o_cpu_stall,
  input wire logic       o_io_hold,
  input wire logic       o_sys_rst,
  input wire logic       o_warm_rst,
  input wire logic       o_wdt_clear,
  input wire logic       o_resume,
  input wire logic       o_int_go,
  input wire logic       o_sysosc_en,
  input wire logic       o_subclk_en,
  input wire logic       o_lcd_en,
  input wire logic       o_lowxtal_en,
  input wire logic       o_low_rc_osc_en,
  input wire logic       o_lvr_en
);
  import pdw_pkg::*;
  logic halt_taken;
  // A halt only counts in normal running with no reset of any kind in the same cycle.
  assign halt_taken = i_halt && !o_cpu_stall && !o_sys_rst && i_ext_rst_pin_n
                      && !(i_lvd_low && o_lvr_en) && !i_wdt_ovf;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  a_halt_enters: assert property (halt_taken |=> o_cpu_stall && o_io_hold)
    else $error("halt did not enter power down");
  a_run_clocks: assert property (!o_cpu_stall |-> o_sysosc_en && o_subclk_en
    && o_lowxtal_en && o_lcd_en) else $error("clock off while running");
  a_lcd_needs_sub: assert property (o_lcd_en |-> o_subclk_en)
    else $error("lcd on without sub clock");
  a_hold_stall: assert property (o_io_hold |-> o_cpu_stall)
    else $error("pins held while cpu runs");
  a_wdt_cleared: assert property (halt_taken && i_wdt_src_low |=> o_wdt_clear)
    else $error("watchdog not cleared on halt");
  a_warm_cause: assert property (o_warm_rst |-> $past(i_wdt_ovf) && $past(o_io_hold))
    else $error("warm reset without watchdog wake");
  a_one_exit: assert property (!(o_resume && o_int_go))
    else $error("resume and interrupt entry together");
  a_resume_exit: assert property (o_resume |-> !o_cpu_stall && $past(o_cpu_stall))
    else $error("resume without leaving stall");
  a_pdc_unused: assert property (i_rd && i_addr == ADDR_PDC |=> o_rdata[6:1] == 6'h00)
    else $error("unimplemented bits read nonzero");
  a_pin_reset: assert property (!i_ext_rst_pin_n |=> o_sys_rst)
    else $error("reset pin low without reset");
  a_lvd_reset: assert property (i_lvd_low && o_lvr_en |=> o_sys_rst)
    else $error("low supply without reset");
  a_lvr_rc_on: assert property (o_lvr_en |-> o_low_rc_osc_en)
    else $error("low voltage reset without low rc");
endmodule
bind pdw_power_ctrl pdw_power_ctrl_sva u_sva (.*);

//--- dv/testbench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
  import pdw_pkg::*;
  logic             i_clk, i_nrst, i_wr, i_rd, i_halt, i_ext_rst_pin_n, i_wdt_clr_instr;
  logic             i_wdt_ovf, i_wdt_src_low, i_lvd_low, i_stack_full, i_sst_opt;
  logic             i_lcd_opt_on, halt_req, rst_req, go;
  logic             o_cpu_stall, o_io_hold, o_sys_rst, o_warm_rst, o_wdt_clear, o_resume;
  logic             o_int_go, o_sysosc_en, o_subclk_en, o_lcd_en, o_lowxtal_en;
  logic             o_low_rc_osc_en, o_lvr_en;
  logic [1:0]       i_addr;
  logic [7:0]       i_wdata, o_rdata, i_int_req, i_int_en, i_porta, pins, irq, pdc, clkv;
  pdw_src_t         i_clk_src;
  int               n_fail, total_checks, cycles, k, n;
  pdw_power_ctrl dut (.*);
  pdw_cpu_model u_cpu (.i_clk(i_clk), .i_halt_req(halt_req), .i_rst_req(rst_req),
    .i_pins(pins), .i_irq(irq), .o_halt(i_halt), .o_rst_pin_n(i_ext_rst_pin_n),
    .o_porta(i_porta), .o_int_req(i_int_req));
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 `CHK(o_rdata, e)
  endtask
  // Pulses one control input for a cycle: 0 halt, 1 watchdog clear, else overflow.
  task automatic pulse(input int sel);
    @(posedge i_clk);
    case (sel)
      0: halt_req <= 1'b1;
      1: i_wdt_clr_instr <= 1'b1;
      default: i_wdt_ovf <= 1'b1;
    endcase
    @(posedge i_clk);
    {halt_req, i_wdt_clr_instr, i_wdt_ovf} <= 3'b000;
  endtask
  // Counts edges until the block resumes after its start-up wait or enters the interrupt.
  task automatic wait_exit();
    k = 0;
    do begin
      @(posedge i_clk);
      #1;
      k++;
    end while (o_resume !== 1'b1 && o_int_go !== 1'b1 && k < 2000);
    go = o_int_go;
  endtask
  task automatic sleep(input logic [7:0] p);
    wr(ADDR_PDC, p);
    pulse(0);
    repeat (3) @(posedge i_clk);
    #1 `CHK(o_io_hold, 1'b1)
  endtask
  initial begin
    {i_nrst, i_wr, i_rd, halt_req, rst_req, i_wdt_clr_instr, i_wdt_ovf} = '0;
    {i_wdt_src_low, i_lvd_low, i_stack_full, i_sst_opt, i_lcd_opt_on} = '0;
    {i_addr, i_wdata, i_int_en, pins, irq} = '0;
    i_clk_src = SRC_CRYSTAL;
    repeat (16) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(ADDR_PDC, PDC_RST);
    rd(ADDR_CLK, CLK_RST);
    rd(ADDR_WAKE, WAKE_RST);
    rd(ADDR_STAT, 8'h00);
    `CHK(o_cpu_stall, 1'b0)
    wr(ADDR_STAT, 8'hFF);
    rd(ADDR_STAT, 8'h00);
    wr(ADDR_PDC, 8'hFF);
    rd(ADDR_PDC, 8'h81);
    wr(ADDR_WAKE, 8'h08);
    // Source, start option, keep-on bits and wake kind vary case by case.
    for (int i = 0; i < 6; i++) begin
      pdc  = (i == 0) ? 8'h81 : (i == 4) ? 8'h80 : 8'h00;
      clkv = 8'h1C | 8'(i % 4);
      wr(ADDR_CLK, clkv);
      @(posedge i_clk);
      i_clk_src     <= (i < 2) ? SRC_CRYSTAL : (i == 2 || i == 5) ? SRC_EXT_RC : SRC_INT_FAST_RC;
      i_sst_opt     <= (i == 1 || i == 2);
      i_lcd_opt_on  <= i[0];
      i_wdt_src_low <= i[0];
      i_int_en      <= (i == 1 || i == 3) ? 8'h03 : 8'h01;
      i_stack_full  <= (i == 3);
      irq           <= 8'h01;
      sleep(pdc);
      `CHK(o_sysosc_en, pdc[7])
      `CHK(o_subclk_en, clkv[0])
      `CHK(o_lcd_en, clkv[0] & (pdc[0] | i[0]))
      `CHK(o_lowxtal_en, clkv[1])
      rd(ADDR_STAT, 8'h05);
      @(posedge i_clk);
      pins <= pins ^ 8'h04;
      repeat (4) @(posedge i_clk);
      #1 `CHK(o_cpu_stall, 1'b1)
      @(posedge i_clk);
      if (i == 0 || i >= 4) pins <= pins ^ 8'h08;
      else irq <= 8'h03;
      wait_exit();
      n = (pdc[7] || (i_clk_src != SRC_CRYSTAL && i_sst_opt)) ? 2 : 1024;
      `CHK(k, n + 4 + int'(i == 1))
      `CHK(go, (i == 1))
      irq <= 8'h00;
      rd(ADDR_STAT, 8'h01);
      pulse(1);
      rd(ADDR_STAT, 8'h00);
    end
    sleep(8'h80);
    pulse(2);
    #1 `CHK(o_warm_rst, 1'b1)
    wait_exit();
    `CHK(go, 1'b0)
    `CHK(k, 3)
    rd(ADDR_STAT, 8'h03);
    wr(ADDR_PDC, 8'h81);
    @(posedge i_clk);
    rst_req <= 1'b1;
    repeat (4) @(posedge i_clk);
    #1 `CHK(o_sys_rst, 1'b1)
    rst_req <= 1'b0;
    rd(ADDR_PDC, 8'h00);
    rd(ADDR_STAT, 8'h03);
    wr(ADDR_PDC, 8'h81);
    @(posedge i_clk);
    i_lvd_low <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1 `CHK(o_sys_rst, 1'b1)
    @(posedge i_clk);
    i_lvd_low <= 1'b0;
    rd(ADDR_PDC, 8'h00);
    rd(ADDR_STAT, 8'h03);
    // The low-speed RC and low-voltage reset enables follow the clock control register one edge later.
    wr(ADDR_CLK, 8'h18);
    @(posedge i_clk);
    #1 `CHK({o_low_rc_osc_en, o_lvr_en}, 2'b00)
    wr(ADDR_CLK, 8'h0D);
    @(posedge i_clk);
    #1 `CHK({o_low_rc_osc_en, o_lvr_en}, 2'b11)
    // A second power-on reset in mid-run must clear the power-down flag.
    @(posedge i_clk);
    i_nrst <= 1'b0;
    @(posedge i_clk);
    #1 `CHK({o_sys_rst, o_cpu_stall}, 2'b11)
    @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(ADDR_STAT, 8'h00);
    `CHK({o_sys_rst, o_cpu_stall}, 2'b00)
    print_verdict();
  end
endmodule

//--- logic/pdw_pkg.sv
package pdw_pkg;

  localparam logic [1:0] ADDR_PDC  = 2'h0;
  localparam logic [1:0] ADDR_CLK  = 2'h1;
  localparam logic [1:0] ADDR_STAT = 2'h2;
  localparam logic [1:0] ADDR_WAKE = 2'h3;

  localparam int PDC_SYSOSC_BIT = 7;
  localparam int PDC_LCD_BIT    = 0;
  localparam int CLK_SUB_BIT    = 0;
  localparam int CLK_LXT_BIT    = 1;
  localparam int CLK_REG_BIT    = 2;
  localparam int CLK_LVR_BIT    = 3;
  localparam int CLK_LOW_RC_OSC_BIT   = 4;
  localparam int STAT_PDF_BIT   = 0;
  localparam int STAT_TO_BIT    = 1;
  localparam int STAT_DOWN_BIT  = 2;
  localparam int STAT_WAIT_BIT  = 3;

  localparam logic [7:0] PDC_RST  = 8'h00;
  localparam logic [7:0] CLK_RST  = 8'h1D;
  localparam logic [7:0] WAKE_RST = 8'h00;

  localparam int          SST_W     = 11;
  localparam logic [10:0] SST_LONG  = 11'h400;
  localparam logic [10:0] SST_SHORT = 11'h002;

  typedef enum logic [1:0] {
    SRC_CRYSTAL,
    SRC_EXT_RC,
    SRC_INT_FAST_RC
  } pdw_src_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_DOWN,
    ST_WAIT,
    ST_INT_GAP
  } pdw_state_t;

endpackage

//--- logic/pdw_power_ctrl.sv
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
// What this block does
// - A halt pulse moves the block from normal to power down; else oscillators run.
// - In power down the system oscillator runs only if its keep-on bit is set.
// - Sub clock runs in power down only if its keep-on bit; LCD needs it too.
// - LCD keep-on clear: LCD follows the strap option; set: on while sub clock runs.
// - Power down freezes state: CPU and I/O pins are told to hold.
// - Entering power down clears the watchdog if it counts a low-speed clock.
// - Halt sets the power-down flag and clears the watchdog-expiry flag.
// - Power-on reset and the watchdog clear instruction clear the power-down flag.
// - Wake on reset pin, new interrupt, enabled port A change or watchdog overflow.
// - Pin reset fully resets; watchdog overflow sets expiry flag, warm-resets PC and SP in power down, fully resets while running.
// - Port A wake is per pin; afterwards execution continues after the halt.
// - Interrupt wake resumes next instruction if disabled or stack full, else serves it.
// - Interrupt flags already set at halt cannot wake the device.
// - Start-up wait is 1024 or 2 clocks by source, start option and keep-on bit.
// - Next instruction starts right after the wait; interrupt entry one cycle later.
// - Enabling low-voltage reset forces the low-speed RC oscillator on.
// - Clearing the regulator bit turns off low-speed RC and low-voltage reset.
// - Unimplemented bits of the power-down control register read as zero.
// - After power-on the CPU is released from a zero program counter.
// - Reset pin low resets the running device; release lets execution restart.
// - Low supply report gives a full reset like the reset pin while low-voltage reset is enabled, except in power down.
module pdw_power_ctrl (
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic [1:0]        i_addr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [7:0]        o_rdata,
  input  wire logic              i_halt,
  input  wire logic              i_wdt_clr_instr,
  input  wire logic              i_wdt_ovf,
  input  wire logic              i_wdt_src_low,
  input  wire logic              i_ext_rst_pin_n,
  input  wire logic              i_lvd_low,
  input  wire logic [7:0]        i_int_req,
  input  wire logic [7:0]        i_int_en,
  input  wire logic              i_stack_full,
  input  wire logic [7:0]        i_porta,
  input  wire pdw_pkg::pdw_src_t i_clk_src,
  input  wire logic              i_sst_opt,
  input  wire logic              i_lcd_opt_on,
  output logic                   o_cpu_stall,
  output logic                   o_io_hold,
  output logic                   o_sys_rst,
  output logic                   o_warm_rst,
  output logic                   o_wdt_clear,
  output logic                   o_resume,
  output logic                   o_int_go,
  output logic                   o_sysosc_en,
  output logic                   o_subclk_en,
  output logic                   o_lcd_en,
  output logic                   o_lowxtal_en,
  output logic                   o_low_rc_osc_en,
  output logic                   o_lvr_en
);
  import pdw_pkg::*;

  pdw_state_t state_ff;
  pdw_state_t nxt_state;

  logic [7:0] pdc_ff;
  logic [7:0] clk_ff;
  logic [7:0] wake_en_ff;
  logic       pdf_ff;
  logic       to_ff;
  logic       int_path_ff;
  logic [7:0] rdata_ff;
  logic       stall_ff;
  logic       hold_ff;
  logic       sys_rst_ff;
  logic       warm_ff;
  logic       wclr_ff;
  logic       resume_ff;
  logic       int_go_ff;
  logic       sysosc_ff;
  logic       sub_ff;
  logic       lcd_ff;
  logic       lxt_ff;
  logic       low_rc_osc_ff;
  logic       lvr_ff;

  logic             halt_go;
  logic             pin_rst;
  logic             lvd_rst;
  logic             hard_rst;
  logic             pa_wake;
  logic             irq_wake;
  logic             irq_serve;
  logic             ovf_wake;
  logic             any_wake;
  logic [SST_W-1:0] sst_n;
  logic             sst_done;
  logic             down;

  pdw_wake_if pa_bus ();
  pdw_wake_if irq_bus ();

  assign halt_go = (state_ff == ST_RUN) && i_halt;
  assign down    = (state_ff == ST_DOWN);

  // Low-voltage reset is off in power down and without the regulator.
  assign pin_rst  = !i_ext_rst_pin_n;
  assign lvd_rst  = i_lvd_low && lvr_ff;
  assign hard_rst = pin_rst || lvd_rst;

  // Both detectors snapshot their inputs on the halt cycle.
  assign pa_bus.capture  = halt_go;
  assign pa_bus.vec      = i_porta;
  assign pa_bus.mask     = wake_en_ff;
  assign irq_bus.capture = halt_go;
  assign irq_bus.vec     = i_int_req;
  assign irq_bus.mask    = 8'hFF;

  pdw_wake_det #(
    .EDGE_ANY (1'b1)
  ) u_pa_det (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .bus    (pa_bus.det)
  );

  // Only flags that rise after the snapshot count.
  pdw_wake_det #(
    .EDGE_ANY (1'b0)
  ) u_irq_det (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .bus    (irq_bus.det)
  );

  assign pa_wake   = down && (pa_bus.hit != 8'h00);
  assign irq_wake  = down && (irq_bus.hit != 8'h00);
  assign ovf_wake  = down && i_wdt_ovf;
  assign any_wake  = pa_wake || irq_wake || ovf_wake;
  assign irq_serve = irq_wake && ((irq_bus.hit & i_int_en) != 8'h00)
                     && !i_stack_full;

  always_comb begin
    sst_n = SST_SHORT;
    unique case (i_clk_src)
      SRC_CRYSTAL: begin
        if (!pdc_ff[PDC_SYSOSC_BIT]) begin
          sst_n = SST_LONG;
        end
      end
      SRC_EXT_RC, SRC_INT_FAST_RC: begin
        if (!pdc_ff[PDC_SYSOSC_BIT] && !i_sst_opt) begin
          sst_n = SST_LONG;
        end
      end
      default: begin
        sst_n = SST_SHORT;
      end
    endcase
  end

  pdw_sst_timer u_sst (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_load  (any_wake && !hard_rst),
    .i_count (sst_n),
    .o_busy  (),
    .o_done  (sst_done)
  );

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RUN: begin
        if (halt_go) begin
          nxt_state = ST_DOWN;
        end
      end
      ST_DOWN: begin
        if (any_wake) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (sst_done) begin
          nxt_state = int_path_ff ? ST_INT_GAP : ST_RUN;
        end
      end
      ST_INT_GAP: begin
        nxt_state = ST_RUN;
      end
    endcase
    if (hard_rst) begin
      nxt_state = ST_RUN;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      int_path_ff <= 1'b0;
    end else if (any_wake) begin
      int_path_ff <= irq_serve && !ovf_wake;
    end
  end

  // Halt is the set and wins over a same-cycle clear.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pdf_ff <= 1'b0;
    end else if (halt_go) begin
      pdf_ff <= 1'b1;
    end else if (i_wdt_clr_instr) begin
      pdf_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      to_ff <= 1'b0;
    end else if (i_wdt_ovf) begin
      to_ff <= 1'b1;
    end else if (halt_go || (pin_rst && down)) begin
      to_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pdc_ff     <= PDC_RST;
      clk_ff     <= CLK_RST;
      wake_en_ff <= WAKE_RST;
    end else if (hard_rst) begin
      pdc_ff     <= PDC_RST;
      clk_ff     <= CLK_RST;
      wake_en_ff <= WAKE_RST;
    end else if (i_wr) begin
      unique case (i_addr)
        ADDR_PDC: begin
          pdc_ff[PDC_SYSOSC_BIT] <= i_wdata[PDC_SYSOSC_BIT];
          pdc_ff[PDC_LCD_BIT]    <= i_wdata[PDC_LCD_BIT];
        end
        ADDR_CLK: begin
          clk_ff <= {3'h0, i_wdata[4:0]};
        end
        ADDR_WAKE: begin
          wake_en_ff <= i_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_ff <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        ADDR_PDC: begin
          rdata_ff <= pdc_ff & 8'h81;
        end
        ADDR_CLK: begin
          rdata_ff <= clk_ff;
        end
        ADDR_STAT: begin
          rdata_ff <= {4'h0, (state_ff == ST_WAIT), down, to_ff, pdf_ff};
        end
        ADDR_WAKE: begin
          rdata_ff <= wake_en_ff;
        end
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // Stall covers power down, the start-up wait and the interrupt gap.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      stall_ff <= 1'b1;
      hold_ff  <= 1'b0;
    end else begin
      stall_ff <= (nxt_state != ST_RUN) || hard_rst;
      hold_ff  <= (nxt_state == ST_DOWN);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sys_rst_ff <= 1'b1;
      warm_ff    <= 1'b0;
      wclr_ff    <= 1'b0;
      resume_ff  <= 1'b0;
      int_go_ff  <= 1'b0;
    end else begin
      sys_rst_ff <= hard_rst || (i_wdt_ovf && !down);
      warm_ff    <= ovf_wake && !hard_rst;
      wclr_ff    <= halt_go && i_wdt_src_low;
      resume_ff  <= (state_ff == ST_WAIT) && sst_done && !int_path_ff && !hard_rst;
      int_go_ff  <= (state_ff == ST_INT_GAP) && !hard_rst;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sysosc_ff <= 1'b1;
      sub_ff    <= 1'b1;
      lcd_ff    <= 1'b1;
      lxt_ff    <= 1'b1;
    end else if (nxt_state == ST_DOWN) begin
      sysosc_ff <= pdc_ff[PDC_SYSOSC_BIT];
      sub_ff    <= clk_ff[CLK_SUB_BIT];
      lcd_ff    <= clk_ff[CLK_SUB_BIT]
                   && (pdc_ff[PDC_LCD_BIT] || i_lcd_opt_on);
      lxt_ff    <= clk_ff[CLK_LXT_BIT];
    end else begin
      sysosc_ff <= 1'b1;
      sub_ff    <= 1'b1;
      lcd_ff    <= 1'b1;
      lxt_ff    <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      low_rc_osc_ff <= 1'b1;
      lvr_ff  <= 1'b1;
    end else begin
      lvr_ff  <= clk_ff[CLK_REG_BIT] && clk_ff[CLK_LVR_BIT]
                 && (nxt_state != ST_DOWN);
      low_rc_osc_ff <= clk_ff[CLK_REG_BIT]
                 && (clk_ff[CLK_LOW_RC_OSC_BIT] || clk_ff[CLK_LVR_BIT]);
    end
  end

  assign o_rdata         = rdata_ff;
  assign o_cpu_stall     = stall_ff;
  assign o_io_hold       = hold_ff;
  assign o_sys_rst       = sys_rst_ff;
  assign o_warm_rst      = warm_ff;
  assign o_wdt_clear     = wclr_ff;
  assign o_resume        = resume_ff;
  assign o_int_go        = int_go_ff;
  assign o_sysosc_en     = sysosc_ff;
  assign o_subclk_en     = sub_ff;
  assign o_lcd_en        = lcd_ff;
  assign o_lowxtal_en    = lxt_ff;
  assign o_low_rc_osc_en = low_rc_osc_ff;
  assign o_lvr_en        = lvr_ff;
endmodule

//--- logic/pdw_sst_timer.sv
`timescale 1ns/1ps
// Counts a loaded number of clocks and pulses done on the last one.
module pdw_sst_timer (
  input  wire logic                    i_clk,
  input  wire logic                    i_nrst,
  input  wire logic                    i_load,
  input  wire logic [pdw_pkg::SST_W-1:0] i_count,
  output logic                         o_busy,
  output logic                         o_done
);
  import pdw_pkg::*;

  logic [SST_W-1:0] cnt_ff;
  logic             busy_ff;
  logic             done_ff;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (i_load) begin
        cnt_ff  <= i_count - 11'h001;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        if (cnt_ff == '0) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - 11'h001;
        end
      end
    end
  end

  assign o_busy = busy_ff;
  assign o_done = done_ff;
endmodule

//--- logic/pdw_wake_det.sv
`timescale 1ns/1ps
// Snapshots a vector when power down is entered and flags enabled bits that
// later change (EDGE_ANY) or newly rise (EDGE_ANY = 0).
module pdw_wake_det #(
  parameter bit EDGE_ANY = 1'b1
) (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  pdw_wake_if.det   bus
);
  logic [7:0] snap_ff;
  logic [7:0] hit_ff;
  logic [7:0] nxt_hit;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      snap_ff <= 8'h00;
    end else if (bus.capture) begin
      snap_ff <= bus.vec;
    end
  end

  always_comb begin
    if (EDGE_ANY) begin
      nxt_hit = (bus.vec ^ snap_ff) & bus.mask;
    end else begin
      nxt_hit = bus.vec & ~snap_ff & bus.mask;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hit_ff <= 8'h00;
    end else begin
      hit_ff <= bus.capture ? 8'h00 : nxt_hit;
    end
  end

  assign bus.hit = hit_ff;
endmodule

//--- logic/pdw_wake_if.sv
`timescale 1ns/1ps
interface pdw_wake_if;
  logic       capture;
  logic [7:0] vec;
  logic [7:0] mask;
  logic [7:0] hit;

  modport ctrl (
    output capture,
    output vec,
    output mask,
    input  hit
  );
  modport det (
    input  capture,
    input  vec,
    input  mask,
    output hit
  );
endinterface
